// file: rtl/srsu_ibuf.sv
// command input buffer: character store with line terminator accounting
module srsu_ibuf
  import srsu_pkg::*;
#(
  parameter int W = CHAR_W,
  parameter int DEPTH = IBUF_DEPTH
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic flush,
  // fill side
  input wire logic wr_valid,
  input wire logic [W-1:0] wr_data,
  output logic wr_ready,
  // drain side
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [W-1:0] rd_data,
  output logic line_avail,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d, lines_q, lines_d;
  logic ready_q, ready_d;
  logic push, pop;

  // ************************************************************
  // pointer and count update; depth is assumed a power of two
  // ************************************************************
  always_comb
  begin
    push = wr_valid && ready_q;
    pop = rd_ready && (cnt_q != '0);
    wp_d = push ? wp_q + AW'(1) : wp_q;
    rp_d = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
    lines_d = lines_q + CW'(push && (wr_data == W'(C_TERM))) - CW'(pop && (rd_data == W'(C_TERM)));
    if (flush)
    begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
      lines_d = '0;
    end
    ready_d = (cnt_d != CW'(DEPTH)); // registered so the bus sees a flop
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      lines_q <= '0;
      ready_q <= 1'b1;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      lines_q <= lines_d;
      ready_q <= ready_d;
    end
  end

  // storage has no reset: contents are only read below the count
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wp_q] <= wr_data;
    end
  end

  assign wr_ready = ready_q;
  assign full = !ready_q;
  assign rd_valid = (cnt_q != '0);
  assign rd_data = mem[rp_q];
  assign line_avail = (lines_q != '0);

endmodule

// file: rtl/srsu_pkg.sv
// shared constants, command codes, states and carriers of the service request status unit
package srsu_pkg;

  // ************************************************************
  // status byte, event register and device register bit positions
  // ************************************************************
  localparam int STB_SCAN_BIT = 0;
  localparam int STB_MEAS_BIT = 1;
  localparam int STB_SYNTH_BIT = 2;
  localparam int STB_INST_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_QUERY_ERR_BIT = 2;
  localparam int ESR_CMD_ERR_BIT = 5;
  localparam int ESR_PON_BIT = 7;
  localparam int INST_AUTO_CHANGE_BIT = 8;

  // ************************************************************
  // widths, reset values, sizes, the completion reply and the device command flag
  // ************************************************************
  localparam int CHAR_W = 8;
  localparam int DEV_REG_W = 16;
  localparam int IBUF_DEPTH = 4096;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [15:0] PPOLL_RESET = 16'h0000;
  localparam logic [7:0] ESR_RESET = 8'h00;
  localparam logic [7:0] OPCQ_REPLY = 8'h31;
  localparam logic [7:0] DEV_CMD_FLAG = 8'h80;

  // ************************************************************
  // command byte codes as delivered by the bus front end
  // ************************************************************
  typedef enum logic [7:0] {
    C_NOP  = 8'h00,
    C_STBQ = 8'h01,
    C_ESRQ = 8'h02,
    C_ISTQ = 8'h03,
    C_SREQ = 8'h04,
    C_ESEQ = 8'h05,
    C_CLS  = 8'h06,
    C_RST  = 8'h07,
    C_RCL0 = 8'h08,
    C_OPC  = 8'h09,
    C_TERM = 8'h0A,
    C_OPCQ = 8'h0B,
    C_WAI  = 8'h0C,
    C_SREW = 8'h0D,
    C_ESEW = 8'h0E,
    C_PREW = 8'h0F
  } srsu_cmd_e;

  // command executor states
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_ARG_LO = 2'b01,
    S_ARG_HI = 2'b10,
    S_WAIT   = 2'b11
  } srsu_exec_e;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [15:0] inst;
    logic [15:0] synth;
    logic [15:0] meas;
    logic [15:0] scan;
  } srsu_dev_ev_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } srsu_resp_s;

endpackage

// file: rtl/srsu_top.sv
// service request status unit: status byte, masks, clears and command sequencing
// What this block does
// - status byte query answers without changing anything
// - serial poll sends byte, then drops request
// - clear-status with empty output clears events
// - zero event mask plus read clears byte
// - bits 0-3 are four device summaries
// - bit 4 set while output unread
// - request mask selects request-raising status bits
// - request mask zeroed at power-on if flag
// - 16-bit poll mask yields individual status bit
// - pulsed device bits (such as auto-change bit 8) sticky, level bits live
// - transducer change and index set bits
// - block-ready bit when block count ready
// - status bit 7 unused, bit 5 is event summary
// - power-on clears events, masks per flag
// - device clear empties output, resets processing
// - service request cleared by matching clear events
// - commands buffered, run after line terminator
// - overlong line runs in sections, bus held
// - operation-complete sets event bit 0 when idle
// - completion query also queues a reply
// - wait holds following commands until idle
// - event summary set only by enabled bits
// - event bits sticky until read or cleared
module srsu_top
  import srsu_pkg::*;
#(
  parameter int IBUF_CHARS = IBUF_DEPTH
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // command characters from the bus front end
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  output logic bus_hold,
  // bus control events
  input wire logic dev_clear,
  input wire logic spoll_req,
  input wire logic out_read,
  // power-on strap and retained masks
  input wire logic power_on_clear_flag,
  input wire logic [7:0] nv_sre,
  input wire logic [7:0] nv_ese,
  // device events and state
  input wire srsu_dev_ev_s dev_ev_pulse,
  input wire srsu_dev_ev_s dev_ev_level,
  input wire logic [7:0] esr_ev,
  input wire logic dev_busy,
  input wire logic dev_msg_avail,
  input wire logic [7:0] dev_ist_bits,
  // status results
  output logic [7:0] stb,
  output logic srq,
  output logic ist,
  output logic spoll_valid,
  output logic [7:0] spoll_byte,
  output srsu_resp_s rsp,
  // device control
  output logic dev_cmd_valid,
  output logic [6:0] dev_cmd,
  output logic dev_default,
  output logic obuf_clear
);

  // true when any bit of a device event register is set
  function automatic logic any16(input logic [15:0] v);
    any16 = (v != 16'h0000);
  endfunction

  // ************************************************************
  // input buffer
  // ************************************************************
  logic ib_valid, ib_line, ib_full, ib_pop;
  logic [7:0] ib_data;

  srsu_ibuf #(.W(CHAR_W), .DEPTH(IBUF_CHARS)) u_ibuf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .flush(dev_clear),
    .wr_valid(cmd_valid),
    .wr_data(cmd_byte),
    .wr_ready(cmd_ready),
    .rd_ready(ib_pop),
    .rd_valid(ib_valid),
    .rd_data(ib_data),
    .line_avail(ib_line),
    .full(ib_full)
  );

  // ************************************************************
  // state
  // ************************************************************
  srsu_exec_e st_q, st_d;
  logic [1:0] tgt_q, tgt_d; // 0 request mask, 1 event mask, 2 poll mask
  logic [1:0] wkind_q, wkind_d; // 0 wait only, 1 complete, 2 complete query
  logic [7:0] arg_q, arg_d, sre_q, sre_d, ese_q, ese_d, esr_q, esr_d;
  logic [15:0] pre_q, pre_d;
  srsu_dev_ev_s sticky_q, sticky_d;
  srsu_resp_s rsp_q, rsp_d;
  logic por_done_q, por_done_d, hold_q, hold_d, ack_q, ack_d;
  logic dcmd_v_q, dcmd_v_d, dflt_q, dflt_d, obclr_q, obclr_d;
  logic [6:0] dcmd_q, dcmd_d;
  logic [7:0] stb_q, stb_d, sp_byte_q, sp_byte_d;
  logic srq_q, srq_d, ist_q, ist_d, sp_v_q, sp_v_d;
  srsu_dev_ev_s dev_val;
  logic [7:0] stb_c, esr_set;
  logic mav_c, cond_c, rqs_c, clr_ev, put, esr_rd;
  logic [7:0] put_data;

  // ************************************************************
  // status byte composition
  // ************************************************************
  always_comb
  begin
    dev_val = sticky_q | dev_ev_level; // sticky bits such as auto-change plus live function bits
    mav_c = rsp_q.valid || dev_msg_avail;
    stb_c = 8'h00;
    stb_c[STB_SCAN_BIT] = any16(dev_val.scan);
    stb_c[STB_MEAS_BIT] = any16(dev_val.meas);
    stb_c[STB_SYNTH_BIT] = any16(dev_val.synth);
    stb_c[STB_INST_BIT] = any16(dev_val.inst);
    stb_c[STB_MAV_BIT] = mav_c;
    stb_c[STB_ESB_BIT] = (esr_q & ese_q) != 8'h00; // self-clearing summary
    cond_c = (stb_c[5:0] & sre_q[5:0]) != 6'h00;
    rqs_c = cond_c && !ack_q; // a poll acknowledges until the condition drops
    stb_c[STB_RQS_BIT] = rqs_c;
  end

  // ************************************************************
  // command executor and register next values
  // ************************************************************
  always_comb
  begin
    st_d = st_q;
    tgt_d = tgt_q;
    wkind_d = wkind_q;
    arg_d = arg_q;
    sre_d = sre_q;
    ese_d = ese_q;
    pre_d = pre_q;
    por_done_d = 1'b1;
    dcmd_v_d = 1'b0;
    dcmd_d = dcmd_q;
    dflt_d = 1'b0;
    obclr_d = dev_clear;
    clr_ev = 1'b0;
    esr_rd = 1'b0;
    put = 1'b0;
    put_data = 8'h00;
    esr_set = esr_ev;
    // a full buffer is drained in sections while the bus is held
    hold_d = ib_full || (hold_q && ib_valid);
    // complete lines run, or sections of a full or held buffer; waits block everything behind them
    ib_pop = ib_valid && (ib_line || hold_q || ib_full) && (st_q != S_WAIT) && !dev_clear;
    if (!por_done_q)
    begin
      esr_set[ESR_PON_BIT] = 1'b1; // power-on bit set after the clear
      if (!power_on_clear_flag)
      begin
        sre_d = nv_sre; // masks survive when the flag is 0
        ese_d = nv_ese;
      end
    end
    case (st_q)
      S_IDLE:
      begin
        if (ib_pop)
        begin
          case (srsu_cmd_e'(ib_data))
            C_NOP, C_TERM: ;
            C_STBQ:
            begin
              put = 1'b1; // read-only view of the byte
              put_data = stb_c;
            end
            C_ESRQ:
            begin
              put = 1'b1;
              put_data = esr_q;
              esr_rd = 1'b1;
            end
            C_ISTQ:
            begin
              put = 1'b1;
              put_data = {7'h00, ist_q};
            end
            C_SREQ:
            begin
              put = 1'b1;
              put_data = sre_q;
            end
            C_ESEQ:
            begin
              put = 1'b1;
              put_data = ese_q;
            end
            C_CLS: clr_ev = !mav_c;
            C_RST, C_RCL0: dflt_d = 1'b1; // event register untouched
            C_OPC:
            begin
              st_d = S_WAIT;
              wkind_d = 2'd1;
            end
            C_OPCQ:
            begin
              st_d = S_WAIT;
              wkind_d = 2'd2;
            end
            C_WAI:
            begin
              st_d = S_WAIT;
              wkind_d = 2'd0;
            end
            C_SREW, C_ESEW, C_PREW:
            begin
              st_d = S_ARG_LO;
              tgt_d = ib_data[1:0] - 2'd1;
            end
            default:
            begin
              if ((ib_data & DEV_CMD_FLAG) != 8'h00)
              begin
                dcmd_v_d = 1'b1;
                dcmd_d = ib_data[6:0];
              end
              else
              begin
                esr_set[ESR_CMD_ERR_BIT] = 1'b1;
              end
            end
          endcase
        end
      end
      S_ARG_LO:
      begin
        if (ib_pop)
        begin
          arg_d = ib_data;
          st_d = S_IDLE;
          case (tgt_q)
            2'd0: sre_d = ib_data;
            2'd1: ese_d = ib_data;
            default: st_d = S_ARG_HI;
          endcase
        end
      end
      S_ARG_HI:
      begin
        if (ib_pop)
        begin
          pre_d = {ib_data, arg_q}; // low byte first
          st_d = S_IDLE;
        end
      end
      S_WAIT:
      begin
        // a command issued last cycle may not have raised busy yet
        if (!dev_busy && !dcmd_v_q)
        begin
          st_d = S_IDLE;
          if (wkind_q != 2'd0)
          begin
            esr_set[ESR_OPC_BIT] = 1'b1;
          end
          if (wkind_q == 2'd2)
          begin
            put = 1'b1;
            put_data = OPCQ_REPLY;
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
    // a new reply over an unread one is a query error
    if (put && rsp_q.valid)
    begin
      esr_set[ESR_QUERY_ERR_BIT] = 1'b1;
    end
    // set wins over the clear in the same cycle
    esr_d = ((clr_ev || esr_rd) ? ESR_RESET : esr_q) | esr_set;
    sticky_d = (clr_ev ? '0 : sticky_q) | dev_ev_pulse;
    rsp_d = rsp_q;
    if (out_read)
    begin
      rsp_d.valid = 1'b0;
    end
    if (put)
    begin
      rsp_d.valid = 1'b1;
      rsp_d.data = put_data;
    end
    if (dev_clear)
    begin
      rsp_d.valid = 1'b0; // clears buffer, not events or masks
      st_d = S_IDLE;
      hold_d = 1'b0;
    end
  end

  // ************************************************************
  // service request, poll and registered status outputs
  // ************************************************************
  always_comb
  begin
    ack_d = cond_c && (ack_q || spoll_req);
    sp_v_d = spoll_req;
    sp_byte_d = spoll_req ? stb_c : sp_byte_q;
    stb_d = stb_c;
    srq_d = rqs_c;
    ist_d = (pre_q & {dev_ist_bits, stb_c}) != 16'h0000;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= S_IDLE;
      tgt_q <= 2'd0;
      wkind_q <= 2'd0;
      arg_q <= 8'h00;
      sre_q <= SRE_RESET;
      ese_q <= ESE_RESET;
      esr_q <= ESR_RESET;
      pre_q <= PPOLL_RESET;
      sticky_q <= '0;
      rsp_q <= '0;
      por_done_q <= 1'b0;
      hold_q <= 1'b0;
      ack_q <= 1'b0;
      dcmd_v_q <= 1'b0;
      dcmd_q <= 7'h00;
      dflt_q <= 1'b0;
      obclr_q <= 1'b0;
      stb_q <= 8'h00;
      srq_q <= 1'b0;
      ist_q <= 1'b0;
      sp_v_q <= 1'b0;
      sp_byte_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      tgt_q <= tgt_d;
      wkind_q <= wkind_d;
      arg_q <= arg_d;
      sre_q <= sre_d;
      ese_q <= ese_d;
      esr_q <= esr_d;
      pre_q <= pre_d;
      sticky_q <= sticky_d;
      rsp_q <= rsp_d;
      por_done_q <= por_done_d;
      hold_q <= hold_d;
      ack_q <= ack_d;
      dcmd_v_q <= dcmd_v_d;
      dcmd_q <= dcmd_d;
      dflt_q <= dflt_d;
      obclr_q <= obclr_d;
      stb_q <= stb_d;
      srq_q <= srq_d;
      ist_q <= ist_d;
      sp_v_q <= sp_v_d;
      sp_byte_q <= sp_byte_d;
    end
  end

  assign stb = stb_q;
  assign srq = srq_q;
  assign ist = ist_q;
  assign spoll_valid = sp_v_q;
  assign spoll_byte = sp_byte_q;
  assign rsp = rsp_q;
  assign dev_cmd_valid = dcmd_v_q;
  assign dev_cmd = dcmd_q;
  assign dev_default = dflt_q;
  assign obuf_clear = obclr_q;
  assign bus_hold = hold_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_stbq_reply;
    (st_q == S_IDLE) && ib_pop && (ib_data == C_STBQ) && !dev_clear |=> rsp_q.valid && rsp_q.data == $past(stb_c);
  endproperty
  a_stbq_reply: assert property (p_stbq_reply) else $error("status query reply wrong");

  property p_poll_drops;
    spoll_req && cond_c |=> !rqs_c ##1 !srq_q;
  endproperty
  a_poll_drops: assert property (p_poll_drops) else $error("request survived poll");

  property p_cls;
    (st_q == S_IDLE) && ib_pop && (ib_data == C_CLS) && !mav_c && esr_ev == 8'h00 && !dev_clear
      |=> esr_q == 8'h00;
  endproperty
  a_cls: assert property (p_cls) else $error("clear status left events");

  property p_mav;
    ##1 stb_q[STB_MAV_BIT] == $past(rsp_q.valid || dev_msg_avail);
  endproperty
  a_mav: assert property (p_mav) else $error("message bit wrong");

  property p_srq;
    ##1 srq_q == $past(((stb_c[5:0] & sre_q[5:0]) != 6'h00) && !ack_q);
  endproperty
  a_srq: assert property (p_srq) else $error("service request mismatch");

  property p_ist;
    ##1 ist_q == $past((pre_q & {dev_ist_bits, stb_c}) != 16'h0000);
  endproperty
  a_ist: assert property (p_ist) else $error("individual status wrong");

  property p_dcl_keeps_sre;
    dev_clear && por_done_q |=> sre_q == $past(sre_q) && !rsp_q.valid && st_q == S_IDLE;
  endproperty
  a_dcl_keeps_sre: assert property (p_dcl_keeps_sre) else $error("device clear misbehaved");

  property p_wait_blocks;
    st_q == S_WAIT |-> !ib_pop;
  endproperty
  a_wait_blocks: assert property (p_wait_blocks) else $error("command ran during wait");

  property p_opc;
    st_q == S_WAIT && wkind_q != 2'd0 && !dev_busy && !dcmd_v_q |=> esr_q[ESR_OPC_BIT] && st_q == S_IDLE;
  endproperty
  a_opc: assert property (p_opc) else $error("operation complete not flagged");

  property p_sticky;
    esr_q != 8'h00 && !esr_rd && !clr_ev |=> (esr_q & $past(esr_q)) == $past(esr_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event bit lost");

  property p_esb;
    stb_c[STB_ESB_BIT] == ((esr_q & ese_q) != 8'h00);
  endproperty
  a_esb: assert property (p_esb) else $error("event summary wrong");

  property p_pon;
    !por_done_q |=> esr_q[ESR_PON_BIT];
  endproperty
  a_pon: assert property (p_pon) else $error("power-on bit missing");

  c_poll: cover property (srq_q ##1 spoll_req ##2 !srq_q);
  c_opcq: cover property (st_q == S_WAIT && wkind_q == 2'd2 ##[1:50] rsp_q.valid);
  c_hold: cover property (ib_full ##1 hold_q);
  c_cls: cover property ((st_q == S_IDLE) && ib_pop && ib_data == C_CLS && esr_q != 8'h00);

endmodule

// file: sim/srsu_ctrl_model.sv
// bus controller model: sends command lines, serial polls and output reads
module srsu_ctrl_model
  import srsu_pkg::*;
(
  // clock
  input wire logic core_clk,
  // command characters
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  input wire logic cmd_ready,
  // poll and read pulses
  output logic spoll_req,
  output logic out_read
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    spoll_req = 1'b0;
    out_read = 1'b0;
  end

  // whole line offered; valid held until each char is taken, terminator last
  task automatic send(input logic [7:0] line[$]);
    foreach (line[i])
    begin
      cmd_valid = 1'b1;
      cmd_byte = line[i];
      while (cmd_ready !== 1'b1)
      begin
        @(posedge core_clk);
        #1;
      end
      @(posedge core_clk);
      #1;
    end
    cmd_valid = 1'b0;
    cmd_byte = ~cmd_byte; // a released bus never keeps the last char
  endtask

  // one-cycle serial poll request
  task automatic poll;
    spoll_req = 1'b1;
    @(posedge core_clk);
    #1;
    spoll_req = 1'b0;
  endtask

  // one-cycle pulse: controller consumed the reply
  task automatic read_out;
    out_read = 1'b1;
    @(posedge core_clk);
    #1;
    out_read = 1'b0;
  endtask
endmodule

// file: sim/srsu_top_test.sv
// self-checking testbench of the service request status unit
module srsu_top_test;
  import srsu_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // signals and instances
  // ************************************************************
  logic core_clk, arst_n, cmd_valid, cmd_ready, bus_hold, dev_clear, spoll_req, out_read;
  logic power_on_clear_flag, dev_busy, dev_msg_avail, srq, ist, spoll_valid;
  logic dev_cmd_valid, dev_default, obuf_clear;
  logic [7:0] cmd_byte, nv_sre, nv_ese, esr_ev, dev_ist_bits, stb, spoll_byte;
  logic [6:0] dev_cmd;
  srsu_dev_ev_s dev_ev_pulse, dev_ev_level;
  srsu_resp_s rsp;
  int err_count = 0;
  int checks = 0;
  logic [31:0] seed = 32'hCF8D;
  logic [7:0] hi;
  logic [7:0] long_line[$];
  logic [1:0] full_seen = 2'b00;

  // sticky record of a held bus and a refused char during the long line
  always @(posedge core_clk)
    full_seen <= full_seen | {bus_hold === 1'b1, cmd_ready === 1'b0};

  srsu_top #(.IBUF_CHARS(16)) srsu_top_inst (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .bus_hold(bus_hold), .dev_clear(dev_clear),
    .spoll_req(spoll_req), .out_read(out_read), .power_on_clear_flag(power_on_clear_flag), .nv_sre(nv_sre),
    .nv_ese(nv_ese), .dev_ev_pulse(dev_ev_pulse), .dev_ev_level(dev_ev_level), .esr_ev(esr_ev),
    .dev_busy(dev_busy), .dev_msg_avail(dev_msg_avail), .dev_ist_bits(dev_ist_bits), .stb(stb), .srq(srq),
    .ist(ist), .spoll_valid(spoll_valid), .spoll_byte(spoll_byte), .rsp(rsp), .dev_cmd_valid(dev_cmd_valid),
    .dev_cmd(dev_cmd), .dev_default(dev_default), .obuf_clear(obuf_clear));

  srsu_ctrl_model srsu_ctrl_model_inst (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_ready(cmd_ready), .spoll_req(spoll_req), .out_read(out_read));

  // ************************************************************
  // helpers
  // ************************************************************
  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // expected status byte from its sources; bit 7 is unused
  function automatic logic [7:0] exp_stb(input logic [3:0] sums, input logic mav, esb, rqs);
    return {1'b0, rqs, esb, mav, sums};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  // a write-only line, then time for the executor to drain it
  task automatic cmd(input logic [7:0] line[$]);
    srsu_ctrl_model_inst.send(line);
    tick(10);
  endtask

  // a query line; reply awaited under a bound, then consumed
  task automatic query(input logic [7:0] code, input logic [7:0] exp, input string what);
    int n;
    srsu_ctrl_model_inst.send('{code, C_TERM});
    n = 0;
    while (rsp.valid !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk_bit("rsp_valid", 1'b1, rsp.valid);
    chk_byte(what, exp, rsp.data);
    srsu_ctrl_model_inst.read_out();
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial
  begin
    arst_n = 1'b0;
    dev_clear = 1'b0;
    power_on_clear_flag = 1'b1;
    nv_sre = 8'hFF;
    nv_ese = 8'hFF;
    dev_ev_pulse = '0;
    dev_ev_level = '0;
    esr_ev = 8'h00;
    dev_busy = 1'b0;
    dev_msg_avail = 1'b0;
    dev_ist_bits = 8'h00;
    tick(10);
    arst_n = 1'b1;
    tick(3);
    // power-on with clear flag: masks zero, so the power-on bit raises nothing
    chk_byte("stb", 8'h00, stb);
    chk_bit("srq", 1'b0, srq);
    query(C_ESRQ, 8'h80, "esr");
    query(C_ESRQ, 8'h00, "esr");
    $display("test power_on done");
    // each device register summary lands on its own bit, random bit within it
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      dev_ev_pulse[16 * k + int'(seed[3:0])] = 1'b1;
      tick(1);
      dev_ev_pulse = '0;
      tick(3);
      chk_byte("stb", exp_stb(4'((1 << (k + 1)) - 1), 1'b0, 1'b0, 1'b0), stb);
    end
    cmd('{C_CLS, C_TERM});
    chk_byte("stb", 8'h00, stb);
    // live function bits follow their source, no sticky copy
    dev_ev_level.inst[seed[7:4]] = 1'b1;
    tick(3);
    chk_byte("stb", 8'h08, stb);
    dev_ev_level = '0;
    tick(3);
    chk_byte("stb", 8'h00, stb);
    $display("test summaries done");
    // message available raises a request; query keeps it, poll drops it
    dev_msg_avail = 1'b1;
    cmd('{C_SREW, 8'h10, C_TERM});
    chk_byte("stb", exp_stb(4'h0, 1'b1, 1'b0, 1'b1), stb);
    chk_bit("srq", 1'b1, srq);
    query(C_STBQ, exp_stb(4'h0, 1'b1, 1'b0, 1'b1), "stb_query");
    chk_bit("srq", 1'b1, srq);
    srsu_ctrl_model_inst.poll();
    chk_bit("spoll_valid", 1'b1, spoll_valid);
    chk_byte("spoll_byte", 8'h50, spoll_byte);
    tick(3);
    chk_byte("stb", 8'h10, stb);
    chk_bit("srq", 1'b0, srq);
    dev_msg_avail = 1'b0;
    tick(3);
    chk_byte("stb", 8'h00, stb);
    $display("test poll done");
    // operation complete through the event mask; mask of 32 selects that bit only
    cmd('{C_SREW, 8'h20, C_TERM, C_ESEW, 8'h01, C_TERM, C_OPC, C_TERM});
    chk_byte("stb", exp_stb(4'h0, 1'b0, 1'b1, 1'b1), stb);
    chk_bit("srq", 1'b1, srq);
    cmd('{C_ESEW, 8'h00, C_TERM});
    chk_byte("stb", 8'h00, stb);
    chk_bit("srq", 1'b0, srq);
    srsu_ctrl_model_inst.send('{C_OPCQ, C_TERM});
    tick(10);
    chk_byte("opcq", OPCQ_REPLY, rsp.data);
    chk_byte("stb", 8'h10, stb);
    dev_clear = 1'b1;
    tick(1);
    dev_clear = 1'b0;
    chk_bit("obuf_clear", 1'b1, obuf_clear);
    tick(1);
    chk_bit("rsp_valid", 1'b0, rsp.valid);
    query(C_SREQ, 8'h20, "sre");
    $display("test completion done");
    // parallel poll mask upper byte against device bits
    seed = lfsr(seed);
    hi = 8'h01 << seed[2:0];
    cmd('{C_PREW, 8'h00, hi, C_TERM});
    dev_ist_bits = hi;
    tick(3);
    chk_bit("ist", 1'b1, ist);
    query(C_ISTQ, 8'h01, "ist_query");
    dev_ist_bits = ~hi;
    tick(3);
    chk_bit("ist", 1'b0, ist);
    $display("test parallel_poll done");
    // device command while busy; the wait holds the mask query back, bad byte flags an error
    dev_busy = 1'b1;
    srsu_ctrl_model_inst.send('{8'h85, 8'h7F, C_WAI, C_ESEQ, C_TERM});
    for (int n = 0; n < 20 && dev_cmd_valid !== 1'b1; n++)
      tick(1);
    chk_bit("dev_cmd_valid", 1'b1, dev_cmd_valid);
    chk_byte("dev_cmd", 8'h05, {1'b0, dev_cmd});
    tick(10);
    chk_bit("rsp_valid", 1'b0, rsp.valid);
    dev_busy = 1'b0;
    tick(5);
    chk_bit("rsp_valid", 1'b1, rsp.valid);
    chk_byte("ese", 8'h00, rsp.data);
    srsu_ctrl_model_inst.read_out();
    $display("test wait done");
    // a line longer than the buffer runs in sections with the bus held
    repeat (20) long_line.push_back(C_NOP);
    long_line.push_back(C_TERM);
    srsu_ctrl_model_inst.send(long_line);
    tick(25);
    chk_byte("full_seen", 8'h03, {6'h00, full_seen});
    chk_bit("bus_hold", 1'b0, bus_hold);
    $display("test long_line done");
    // default restore leaves event bits alone
    srsu_ctrl_model_inst.send('{C_RST, C_TERM, C_RCL0, C_TERM});
    for (int n = 0; n < 20 && dev_default !== 1'b1; n++)
      tick(1);
    chk_bit("dev_default", 1'b1, dev_default);
    tick(5);
    query(C_ESRQ, 8'h21, "esr");
    $display("test default done");
    // second power-on without clear flag: retained masks reload
    power_on_clear_flag = 1'b0;
    nv_sre = 8'h20;
    nv_ese = 8'h80;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(4);
    chk_byte("stb", exp_stb(4'h0, 1'b0, 1'b1, 1'b1), stb);
    chk_bit("srq", 1'b1, srq);
    query(C_ESEQ, 8'h80, "ese");
    $display("test retained_masks done");
    give_verdict();
  end
endmodule
